// [verilog/cifd_pkg.sv]
package cifd_pkg;

    // ------------------------------------------------------------
    // flag register
    // ------------------------------------------------------------
    localparam logic [7:0] FLAGS_ADDR      = 8'hF7;
    localparam logic [7:0] FLAGS_RESET     = 8'h02;
    localparam logic [7:0] FLAGS_WR_MASK   = 8'hD7;
    localparam int         PAGE_ADDRESSING_SELECT_HI       = 7;
    localparam int         PAGE_ADDRESSING_SELECT_LO       = 6;
    localparam int         BANK_BIT        = 4;
    localparam int         CARRY_BIT       = 2;
    localparam int         ZERO_BIT        = 1;
    localparam int         GIE_BIT         = 0;
    localparam logic [7:0] SYSCTL0_ADDR    = 8'hFF;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_NOP          = 8'h40;
    localparam logic [7:0] OP_SVC          = 8'h00;
    localparam logic [7:0] OP_HALT         = 8'h30;
    localparam logic [7:0] OP_PUSH_A       = 8'h08;
    localparam logic [7:0] OP_PUSH_X       = 8'h10;
    localparam logic [7:0] OP_LONG_JUMP         = 8'h7D;
    localparam logic [7:0] OP_LONG_CALL        = 8'h7C;
    localparam logic [7:0] OP_AND_F        = 8'h70;
    localparam logic [7:0] OP_OR_F         = 8'h71;
    localparam logic [7:0] OP_XOR_F        = 8'h72;
    localparam logic [7:0] OP_MOV_DD       = 8'h5F;
    localparam logic [15:0] SVC_VECTOR     = 16'h0000;
    localparam logic [15:0] IRQ_VECTOR     = 16'h0004;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    localparam logic [7:0] SP_RESET        = 8'h00;
    localparam logic [7:0] PAGE_RESET      = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {LEN1, LEN2, LEN3} cifd_len_type;

    typedef enum logic [2:0] {
        FMT_ONE, FMT_REL, FMT_IMM, FMT_ADR, FMT_ABS, FMT_ADI, FMT_ADA
    } cifd_fmt_type;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } cifd_reg_req_type;

    typedef struct packed {
        logic [10:0] addr;
        logic [7:0]  wdata;
        logic        we;
    } cifd_ram_req_type;

    typedef struct packed {
        cifd_fmt_type fmt;
        logic [7:0]   opcode;
        logic [7:0]   op1;
        logic [7:0]   op2;
        logic [15:0]  target;
    } cifd_dec_type;

endpackage

// [verilog/cifd_length.sv]
module cifd_length
(
    // opcode in
    input  wire logic [7:0]              opcode_i,
    // format out
    output cifd_pkg::cifd_len_type       len_o,
    output cifd_pkg::cifd_fmt_type       fmt_o
);

    // ------------------------------------------------------------
    // length from first byte only
    // ------------------------------------------------------------
    // length before operands
    always_comb
    begin
        fmt_o = cifd_pkg::FMT_ADR;
        if (opcode_i[7])
            fmt_o = cifd_pkg::FMT_REL;
        else if (opcode_i == cifd_pkg::OP_LONG_JUMP
                 || opcode_i == cifd_pkg::OP_LONG_CALL)
            fmt_o = cifd_pkg::FMT_ABS;
        else if (opcode_i == cifd_pkg::OP_MOV_DD)
            fmt_o = cifd_pkg::FMT_ADA;
        else if (opcode_i[2:0] == 3'h6 || opcode_i[2:0] == 3'h7)
            fmt_o = cifd_pkg::FMT_ADI;
        else if (opcode_i[2:0] == 3'h1 || opcode_i[7:4] == 4'h7)
            fmt_o = cifd_pkg::FMT_IMM;
        else if (opcode_i[2:0] == 3'h0 || opcode_i == cifd_pkg::OP_NOP
                 || opcode_i[7:3] == 5'h06 || opcode_i == 8'h4B)
            fmt_o = cifd_pkg::FMT_ONE;
        case (fmt_o)
            cifd_pkg::FMT_ONE: len_o = cifd_pkg::LEN1;
            cifd_pkg::FMT_ABS,
            cifd_pkg::FMT_ADI,
            cifd_pkg::FMT_ADA: len_o = cifd_pkg::LEN3;
            default:           len_o = cifd_pkg::LEN2;
        endcase
    end

endmodule // cifd_length

// [verilog/cifd_decoder.sv]
// Operation
// - one-byte instructions are an 8-bit opcode with no operands
// - no-op only advances the program counter
// - supervisor call jumps into supervisory rom code
// - two push opcodes write ram and increment stack pointer
// - halt alone writes user register FFh
// - short branches: 4-bit opcode, 12-bit signed offset
// - immediate format: second byte is constant to core register
// - address format: opcode plus one 8-bit operand address
// - long jump and call: 16-bit target, high byte first
// - three-byte: opcode, destination address, immediate data
// - direct move: opcode, destination, then source address
// - flags: page 7:6, bank 4, carry 2, zero 1, gie 0; reset 02
// - flags readable, changed by and, or, xor immediate
// - flag address reached whatever the bank bit
// - bank bit is ninth register address bit
// - page mode selects pointers forming ram addresses
// - irq sampled once per instruction only when gie set
// - interrupt pushes flags first, then clears gie
// - carry and zero follow results and flag logic
// - program bytes come over a separate fetch bus
// - crossing a 256-byte flash page costs one cycle (here only when an operand byte sits at offset 00h of a page)
module cifd_decoder
(
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // program fetch bus
    output logic [15:0]                   fetch_addr_o,
    output logic                          fetch_req_o,
    input  wire logic [7:0]               fetch_data_i,
    input  wire logic                     fetch_valid_i,
    // register bus
    output cifd_pkg::cifd_reg_req_type    reg_req_o,
    input  wire logic [7:0]               reg_rdata_i,
    // ram bus
    output cifd_pkg::cifd_ram_req_type    ram_req_o,
    // paging and result inputs
    input  wire logic [2:0]               cur_page_i,
    input  wire logic [2:0]               stk_page_i,
    input  wire logic [2:0]               idx_page_i,
    input  wire logic [7:0]               acc_i,
    input  wire logic [7:0]               idx_i,
    input  wire logic                     alu_valid_i,
    input  wire logic                     alu_carry_i,
    input  wire logic                     alu_zero_i,
    input  wire logic                     irq_i,
    // decode and status
    output cifd_pkg::cifd_dec_type        dec_o,
    output logic                          dec_valid_o,
    output logic                          svc_o,
    output logic                          irq_ack_o,
    output logic [7:0]                    flags_o,
    output logic [7:0]                    stack_ptr_o
);

    typedef enum logic [2:0] {
        ST_OP, ST_B1, ST_B2, ST_EXEC, ST_PAGE, ST_IRQ
    } cifd_state_type;

    cifd_state_type             state_r;
    cifd_pkg::cifd_len_type     len_w;
    cifd_pkg::cifd_fmt_type     fmt_w;
    cifd_pkg::cifd_len_type     len_r;
    cifd_pkg::cifd_fmt_type     fmt_r;
    logic [15:0]                pc_r;
    logic [15:0]                inst_pc_r;
    logic [7:0]                 op_r;
    logic [7:0]                 b1_r;
    logic [7:0]                 b2_r;
    logic [7:0]                 flags_r;
    logic [7:0]                 sp_r;
    logic                       crossed_r;
    logic [15:0]                rel_tgt;
    logic [15:0]                next_pc;
    logic [7:0]                 flag_new;

    function automatic logic [10:0] ram_addr(input logic [7:0] a,
                                             input logic idx,
                                             input logic [7:0] f,
                                             input logic [2:0] cp,
                                             input logic [2:0] ip);
        logic [2:0] pg;
        pg = 3'h0;
        if (idx && f[cifd_pkg::PAGE_ADDRESSING_SELECT_LO])
            pg = ip;
        else if (f[cifd_pkg::PAGE_ADDRESSING_SELECT_HI])
            pg = cp;
        ram_addr = {pg, a};
    endfunction

    cifd_length u_len
    (
        .opcode_i (fetch_data_i),
        .len_o    (len_w),
        .fmt_o    (fmt_w)
    );

    assign rel_tgt = inst_pc_r + {{4{op_r[3]}}, op_r[3:0], b1_r};
    assign next_pc = pc_r;

    // ------------------------------------------------------------
    // flag logic value
    // ------------------------------------------------------------
    // and / or / xor immediate
    always_comb
    begin
        flag_new = flags_r;
        if (op_r == cifd_pkg::OP_AND_F)
            flag_new = flags_r & b1_r;
        else if (op_r == cifd_pkg::OP_OR_F)
            flag_new = flags_r | b1_r;
        else if (op_r == cifd_pkg::OP_XOR_F)
            flag_new = flags_r ^ b1_r;
        flag_new = flag_new & cifd_pkg::FLAGS_WR_MASK;
    end

    // ------------------------------------------------------------
    // fetch sequencer
    // ------------------------------------------------------------
    // own fetch bus
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r      <= ST_OP;
            pc_r         <= cifd_pkg::PC_RESET;
            inst_pc_r    <= cifd_pkg::PC_RESET;
            op_r         <= 8'h00;
            b1_r         <= 8'h00;
            b2_r         <= 8'h00;
            len_r        <= cifd_pkg::LEN1;
            fmt_r        <= cifd_pkg::FMT_ONE;
            crossed_r    <= 1'b0;
            fetch_req_o  <= 1'b1;
            fetch_addr_o <= cifd_pkg::PC_RESET;
        end
        else
        begin
            case (state_r)
                ST_OP:
                begin
                    if (fetch_valid_i)
                    begin
                        op_r      <= fetch_data_i;
                        len_r     <= len_w;
                        fmt_r     <= fmt_w;
                        inst_pc_r <= pc_r;
                        crossed_r <= 1'b0;
                        pc_r      <= pc_r + 16'h0001;
                        fetch_addr_o <= pc_r + 16'h0001;
                        if (len_w == cifd_pkg::LEN1)
                        begin
                            fetch_req_o <= 1'b0;
                            state_r     <= ST_EXEC;
                        end
                        else
                            state_r <= ST_B1;
                    end
                end
                ST_B1:
                begin
                    if (fetch_valid_i)
                    begin
                        b1_r <= fetch_data_i;
                        pc_r <= pc_r + 16'h0001;
                        fetch_addr_o <= pc_r + 16'h0001;
                        if (pc_r[7:0] == 8'h00)
                            crossed_r <= 1'b1;
                        if (len_r == cifd_pkg::LEN3)
                            state_r <= ST_B2;
                        else
                        begin
                            fetch_req_o <= 1'b0;
                            state_r     <= ST_EXEC;
                        end
                    end
                end
                ST_B2:
                begin
                    if (fetch_valid_i)
                    begin
                        b2_r <= fetch_data_i;
                        pc_r <= pc_r + 16'h0001;
                        if (pc_r[7:0] == 8'h00)
                            crossed_r <= 1'b1;
                        fetch_req_o <= 1'b0;
                        state_r     <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    if (crossed_r)
                        state_r <= ST_PAGE;
                    else if (flags_r[cifd_pkg::GIE_BIT] && irq_i)
                        state_r <= ST_IRQ;
                    else
                    begin
                        state_r     <= ST_OP;
                        fetch_req_o <= 1'b1;
                    end
                    if (fmt_r == cifd_pkg::FMT_ABS)
                    begin
                        pc_r         <= {b1_r, b2_r};
                        fetch_addr_o <= {b1_r, b2_r};
                    end
                    else if (fmt_r == cifd_pkg::FMT_REL)
                    begin
                        pc_r         <= rel_tgt;
                        fetch_addr_o <= rel_tgt;
                    end
                    else if (op_r == cifd_pkg::OP_SVC)
                    begin
                        pc_r         <= cifd_pkg::SVC_VECTOR;
                        fetch_addr_o <= cifd_pkg::SVC_VECTOR;
                    end
                    else
                        fetch_addr_o <= next_pc;
                end
                ST_PAGE:
                begin
                    crossed_r <= 1'b0;
                    if (flags_r[cifd_pkg::GIE_BIT] && irq_i)
                        state_r <= ST_IRQ;
                    else
                    begin
                        state_r     <= ST_OP;
                        fetch_req_o <= 1'b1;
                    end
                end
                default:
                begin
                    pc_r         <= cifd_pkg::IRQ_VECTOR;
                    fetch_addr_o <= cifd_pkg::IRQ_VECTOR;
                    fetch_req_o  <= 1'b1;
                    state_r      <= ST_OP;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // flags, stack and side effects
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_r     <= cifd_pkg::FLAGS_RESET;
            sp_r        <= cifd_pkg::SP_RESET;
            reg_req_o   <= '0;
            ram_req_o   <= '0;
            dec_o       <= '0;
            dec_valid_o <= 1'b0;
            svc_o       <= 1'b0;
            irq_ack_o   <= 1'b0;
        end
        else
        begin
            reg_req_o   <= '0;
            ram_req_o   <= '0;
            dec_valid_o <= 1'b0;
            svc_o       <= 1'b0;
            irq_ack_o   <= 1'b0;
            if (state_r == ST_EXEC)
            begin
                dec_o.fmt    <= fmt_r;
                dec_o.opcode <= op_r;
                dec_o.op1    <= b1_r;
                dec_o.op2    <= b2_r;
                dec_o.target <= (fmt_r == cifd_pkg::FMT_ABS)
                                ? {b1_r, b2_r} : rel_tgt;
                dec_valid_o  <= 1'b1;
                // no-op and call leave state alone
                if (op_r == cifd_pkg::OP_SVC)
                    svc_o <= 1'b1;
                else if (op_r == cifd_pkg::OP_PUSH_A
                         || op_r == cifd_pkg::OP_PUSH_X)
                begin
                    ram_req_o.addr  <= {stk_page_i, sp_r};
                    ram_req_o.wdata <= op_r[4] ? idx_i : acc_i;
                    ram_req_o.we    <= 1'b1;
                    sp_r            <= sp_r + 8'h01;
                end
                else if (op_r == cifd_pkg::OP_HALT)
                begin
                    reg_req_o.addr  <= {1'b0, cifd_pkg::SYSCTL0_ADDR};
                    reg_req_o.wdata <= 8'h01;
                    reg_req_o.we    <= 1'b1;
                end
                else if (op_r == cifd_pkg::OP_AND_F
                         || op_r == cifd_pkg::OP_OR_F
                         || op_r == cifd_pkg::OP_XOR_F)
                    flags_r <= flag_new;
                else if (fmt_r == cifd_pkg::FMT_ADA)
                begin
                    ram_req_o.addr <= ram_addr(b2_r, 1'b0, flags_r,
                                               cur_page_i, idx_page_i);
                end
                else if (fmt_r == cifd_pkg::FMT_ADR
                         || fmt_r == cifd_pkg::FMT_ADI)
                begin
                    if (b1_r == cifd_pkg::FLAGS_ADDR)
                        reg_req_o.addr <= {1'b0, b1_r};
                    else
                        reg_req_o.addr <= {flags_r[cifd_pkg::BANK_BIT],
                                           b1_r};
                    reg_req_o.re   <= 1'b1;
                    ram_req_o.addr <= ram_addr(op_r[0] ? idx_i + b1_r
                                               : b1_r, op_r[0], flags_r,
                                               cur_page_i, idx_page_i);
                end
                if (alu_valid_i && fmt_r != cifd_pkg::FMT_IMM)
                begin
                    flags_r[cifd_pkg::CARRY_BIT] <= alu_carry_i;
                    flags_r[cifd_pkg::ZERO_BIT]  <= alu_zero_i;
                end
            end
            else if (state_r == ST_IRQ)
            begin
                ram_req_o.addr  <= {stk_page_i, sp_r};
                ram_req_o.wdata <= flags_r;
                ram_req_o.we    <= 1'b1;
                sp_r            <= sp_r + 8'h01;
                flags_r[cifd_pkg::GIE_BIT] <= 1'b0;
                irq_ack_o       <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    // readable flags
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_o     <= cifd_pkg::FLAGS_RESET;
            stack_ptr_o <= cifd_pkg::SP_RESET;
        end
        else
        begin
            flags_o     <= flags_r;
            stack_ptr_o <= sp_r;
        end
    end

    // unused read data kept for later register-read paths
    logic unused_rd;
    assign unused_rd = ^reg_rdata_i;

endmodule // cifd_decoder

// [dv/cifd_decoder_sva.sv]
module cifd_decoder_sva
(
    // clock and reset
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    // watched ports
    input wire logic [15:0]            fetch_addr_o,
    input wire logic                   fetch_req_o,
    input wire logic                   fetch_valid_i,
    input wire cifd_pkg::cifd_dec_type dec_o,
    input wire logic                   dec_valid_o,
    input wire logic                   svc_o,
    input wire logic                   irq_ack_o,
    input wire logic [7:0]             flags_o
);

    // ------------------------------------------------------------
    // cycles since gie was last seen set, saturating
    // ------------------------------------------------------------
    logic [3:0] gie_age_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            gie_age_r <= 4'hF;
        else if (flags_o[cifd_pkg::GIE_BIT])
            gie_age_r <= 4'h0;
        else if (gie_age_r != 4'hF)
            gie_age_r <= gie_age_r + 4'h1;
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_flags_reset: assert property (disable iff (1'b0)
        rst_i ##1 rst_i |-> flags_o == cifd_pkg::FLAGS_RESET)
        else $error("flags not at reset value");
    a_rsvd_zero: assert property (
        flags_o[5] == 1'b0 && flags_o[3] == 1'b0)
        else $error("reserved flag bit set");
    a_irq_gate: assert property (
        irq_ack_o |-> gie_age_r < 4'h8)
        else $error("interrupt taken with gie clear");
    a_gie_clear: assert property (
        irq_ack_o |-> ##[0:4] !flags_o[cifd_pkg::GIE_BIT])
        else $error("gie not cleared on interrupt");
    a_svc_vector: assert property (
        svc_o |-> ##[0:6]
        (fetch_req_o && fetch_addr_o == cifd_pkg::SVC_VECTOR))
        else $error("supervisor call missed its vector");
    a_irq_vector: assert property (
        irq_ack_o |-> ##[0:8]
        (fetch_req_o && fetch_addr_o == cifd_pkg::IRQ_VECTOR))
        else $error("interrupt missed its vector");
    a_long_target: assert property (
        dec_valid_o && dec_o.fmt == cifd_pkg::FMT_ABS
        |-> dec_o.target == {dec_o.op1, dec_o.op2} ##[0:4]
        (fetch_req_o && fetch_addr_o == dec_o.target))
        else $error("long target wrong");
    a_answer_lat: assert property (
        dec_valid_o |-> $past(fetch_valid_i, 2) && $past(fetch_req_o, 2)
        && !$past(fetch_req_o))
        else $error("decode not two cycles after last byte");

endmodule // cifd_decoder_sva

bind cifd_decoder cifd_decoder_sva u_sva (.*);

// [dv/cifd_flash_model.sv]
module cifd_flash_model
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // program fetch bus
    input  wire logic [15:0] fetch_addr_i,
    input  wire logic        fetch_req_i,
    output logic [7:0]       fetch_data_o,
    output logic             fetch_valid_o,
    // pacing and interrupt source
    input  wire logic        slow_i,
    input  wire logic        irq_req_i,
    output logic             irq_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] mem [0:65535];
    logic       tog_r = 1'b0;
    logic [7:0] last_r = 8'h00;

    always_ff @(posedge clk_i)
    begin
        tog_r <= rst_i ? 1'b0 : ~tog_r;
        if (fetch_valid_o)
            last_r <= fetch_data_o;
    end

    // own fetch path
    // slow mode answers every other cycle only
    assign fetch_valid_o = fetch_req_i && !rst_i && (!slow_i || tog_r);
    // no stale byte shown while idle
    assign fetch_data_o = fetch_valid_o ? mem[fetch_addr_i] : ~last_r;
    assign irq_o = irq_req_i;

endmodule // cifd_flash_model

// [dv/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0, irq_req = 1'b1;
    logic [7:0] acc_i = 8'h5A, idx_i = 8'hA5, reg_rdata_i = 8'h00;
    logic alu_valid_i = 1'b0, alu_carry_i = 1'b0, alu_zero_i = 1'b0;
    logic [2:0] cur_page_i = 3'h1, stk_page_i = 3'h5, idx_page_i = 3'h2;
    logic [15:0] fetch_addr_o;
    logic [7:0] fetch_data_i, flags_o, stack_ptr_o;
    logic fetch_req_o, fetch_valid_i, irq_i, dec_valid_o, svc_o, irq_ack_o;
    cifd_pkg::cifd_reg_req_type reg_req_o, last_reg, last_rd;
    cifd_pkg::cifd_ram_req_type ram_req_o, last_ram;
    cifd_pkg::cifd_dec_type     dec_o;
    int num_errors = 0, checked = 0, n = 0;
    int ram_cnt = 0, reg_cnt = 0, svc_cnt = 0, irq_cnt = 0, flag_push = 0;

    always #2.5 clk_i = ~clk_i;

    cifd_decoder u_dut (.*);

    cifd_flash_model u_flash (.clk_i(clk_i), .rst_i(rst_i),
        .fetch_addr_i(fetch_addr_o), .fetch_req_i(fetch_req_o),
        .fetch_data_o(fetch_data_i), .fetch_valid_o(fetch_valid_i),
        .slow_i(slow), .irq_req_i(irq_req), .irq_o(irq_i));

    // ------------------------------------------------------------
    // side effect monitor
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (ram_req_o.we === 1'b1)
        begin
            ram_cnt++;
            last_ram = ram_req_o;
            if (ram_req_o.wdata === 8'h17 && ram_req_o.addr[10:8] === 3'h5)
                flag_push++;
        end
        if (reg_req_o.we === 1'b1)
        begin
            reg_cnt++;
            last_reg = reg_req_o;
        end
        if (reg_req_o.re === 1'b1)
            last_rd = reg_req_o;
        if (svc_o === 1'b1)
            svc_cnt++;
        if (irq_ack_o === 1'b1)
            irq_cnt++;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic load(input logic [15:0] a, input logic [7:0] b[$]);
        foreach (b[k])
            u_flash.mem[a + 16'(k)] = b[k];
    endtask

    // returns in the cycle where the decode pulse stands
    task automatic wait_dec(input logic [7:0] op,
                            input cifd_pkg::cifd_fmt_type f);
        int i;
        i = 0;
        @(posedge clk_i);
        #1;
        while (dec_valid_o !== 1'b1 && i < 400)
        begin
            @(posedge clk_i);
            #1;
            i++;
        end
        if (i >= 400)
        begin
            num_errors++;
            end_of_test();
        end
        chk("opcode", {8'h00, op}, {8'h00, dec_o.opcode});
        chk("format", {13'h0000, f}, {13'h0000, dec_o.fmt});
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        load(16'h0000, '{8'h7D, 8'h00, 8'h10, 8'h40, 8'h30, 8'h40});
        // program keeps reserved flag bits zero
        load(16'h0010, '{8'h71, 8'h06, 8'h72, 8'hD6, 8'h70, 8'h10,
                         8'h08, 8'h40, 8'h10, 8'h00});
        load(16'h0030, '{8'h90, 8'h10});
        load(16'h0040, '{8'h5F, 8'h31, 8'h32, 8'h2A, 8'h33,
                         8'h36, 8'hF7, 8'h77, 8'h71, 8'h01, 8'h40});
        repeat (16) @(posedge clk_i);
        #1;
        chk("flags", 16'h0002, {8'h00, flags_o});
        @(posedge clk_i);
        rst_i <= 1'b0;
        cur_page_i <= 3'h3;
        wait_dec(cifd_pkg::OP_LONG_JUMP, cifd_pkg::FMT_ABS);
        chk("target", 16'h0010, dec_o.target);
        // later passes through the vector jump elsewhere
        u_flash.mem[16'h0002] = 8'h30;
        wait_dec(cifd_pkg::OP_OR_F, cifd_pkg::FMT_IMM);
        chk("imm", 16'h0006, {8'h00, dec_o.op1});
        wait_dec(cifd_pkg::OP_XOR_F, cifd_pkg::FMT_IMM);
        chk("flags", 16'h0006, {8'h00, flags_o});
        wait_dec(cifd_pkg::OP_AND_F, cifd_pkg::FMT_IMM);
        chk("flags", 16'h00D0, {8'h00, flags_o});
        wait_dec(cifd_pkg::OP_PUSH_A, cifd_pkg::FMT_ONE);
        chk("flags", 16'h0010, {8'h00, flags_o});
        wait_dec(cifd_pkg::OP_NOP, cifd_pkg::FMT_ONE);
        chk("push_data", 16'h005A, {8'h00, last_ram.wdata});
        chk("push_addr", 16'h0500, {5'h00, last_ram.addr});
        chk("stack_ptr", 16'h0001, {8'h00, stack_ptr_o});
        n = ram_cnt + reg_cnt;
        wait_dec(cifd_pkg::OP_PUSH_X, cifd_pkg::FMT_ONE);
        chk("nop_writes", 16'(n), 16'(ram_cnt + reg_cnt));
        wait_dec(cifd_pkg::OP_SVC, cifd_pkg::FMT_ONE);
        chk("push_data", 16'h00A5, {8'h00, last_ram.wdata});
        chk("push_addr", 16'h0501, {5'h00, last_ram.addr});
        chk("stack_ptr", 16'h0002, {8'h00, stack_ptr_o});
        n = ram_cnt + reg_cnt;
        @(posedge clk_i);
        slow <= 1'b1;
        wait_dec(cifd_pkg::OP_LONG_JUMP, cifd_pkg::FMT_ABS);
        chk("svc_pulses", 16'h0001, 16'(svc_cnt));
        chk("svc_writes", 16'(n), 16'(ram_cnt + reg_cnt));
        chk("target", 16'h0030, dec_o.target);
        wait_dec(8'h90, cifd_pkg::FMT_REL);
        chk("rel_target", 16'h0040, dec_o.target);
        // result flags carry and zero for the next non-immediate ops
        @(posedge clk_i);
        alu_valid_i <= 1'b1;
        alu_carry_i <= 1'b1;
        alu_zero_i <= 1'b1;
        wait_dec(cifd_pkg::OP_MOV_DD, cifd_pkg::FMT_ADA);
        chk("dest", 16'h0031, {8'h00, dec_o.op1});
        chk("src", 16'h0032, {8'h00, dec_o.op2});
        wait_dec(8'h2A, cifd_pkg::FMT_ADR);
        chk("addr", 16'h0033, {8'h00, dec_o.op1});
        chk("flags", 16'h0016, {8'h00, flags_o});
        @(posedge clk_i);
        alu_valid_i <= 1'b0;
        wait_dec(8'h36, cifd_pkg::FMT_ADI);
        chk("dest", 16'h00F7, {8'h00, dec_o.op1});
        chk("bank_reg", 16'h0133, {7'h00, last_rd.addr});
        chk("data", 16'h0077, {8'h00, dec_o.op2});
        wait_dec(cifd_pkg::OP_OR_F, cifd_pkg::FMT_IMM);
        chk("irq_early", 16'h0000, 16'(irq_cnt));
        chk("flag_reg", 16'h00F7, {7'h00, last_rd.addr});
        // handler at the vector is a halt
        repeat (400)
        begin
            @(posedge clk_i);
            #1;
            if (reg_cnt != 0)
                break;
        end
        chk("irq_taken", 16'h0001, 16'(irq_cnt));
        chk("flag_push", 16'h0001, 16'(flag_push));
        chk("gie", 16'h0000, {15'h0000, flags_o[0]});
        chk("halt_addr", 16'h00FF, {7'h00, last_reg.addr});
        chk("halt_data", 16'h0001, {8'h00, last_reg.wdata});
        chk("halt_writes", 16'h0001, 16'(reg_cnt));
        end_of_test();
    end

endmodule // tb
